// *** design/mode_seq_pkg.sv ***
package mode_seq_pkg;
   // Operating modes, one-hot
   typedef enum logic [3:0]
   {
      MODE_STOP    = 4'b0001,
      MODE_STARTUP = 4'b0010,
      MODE_RUN     = 4'b0100,
      MODE_HOLD    = 4'b1000
   } mode_t;

   // Run cycle phases, one-hot
   typedef enum logic [4:0]
   {
      PH_IDLE     = 5'b0_0001,
      PH_CLR_IN   = 5'b0_0010,
      PH_READ_IN  = 5'b0_0100,
      PH_PROGRAM  = 5'b0_1000,
      PH_WRITE_OUT = 5'b1_0000
   } phase_t;

   localparam int CLK_HZ          = 40_000_000;
   localparam int BLINK_MIN_MS    = 3000;
   localparam int WDOG_MS         = 100;
   localparam int CYC_MIN_US      = 1000;
   localparam int BLINK_MIN_CYC   = CLK_HZ / 1000 * BLINK_MIN_MS;
   localparam int WDOG_CYC        = CLK_HZ / 1000 * WDOG_MS;
   localparam int CYC_MIN_CYC     = CLK_HZ / 1_000_000 * CYC_MIN_US;
   localparam int BLINK_HALF_CYC  = CLK_HZ / 4;
   localparam int MAX_BREAKPOINTS = 3;
   localparam int STEP_MAX_BP     = 2;
   localparam int CNT_W           = 32;

   // Analog output range codes
   localparam logic [1:0] RANGE_VOLT    = 2'h0;
   localparam logic [1:0] RANGE_CUR_0   = 2'h1;
   localparam logic [1:0] RANGE_CUR_4   = 2'h2;
   localparam logic [15:0] AO_ZERO      = 16'h0000;
   localparam logic [15:0] AO_FOUR_MA   = 16'h1B00;
endpackage

// *** design/plc_operating_mode_sequencer.sv ***
// Notes on behaviour
// - Always exactly one of stop, start-up, run or hold.
// - Stop runs no program; images and timers kept across entry.
// - Stop inhibits outputs, run indicator off after the start-up blink window, stop indicator on.
// - Stop to run calls start-up handler, not cycle-time supervised.
// - Start-up inhibits outputs and keeps stop indicator off.
// - Run indicator blinks from start-up entry for at least 3 s.
// - Handler done moves the controller into run.
// - Run executes cyclic program each cycle; timers active; image refreshed.
// - Run releases output inhibit, run indicator on after the start-up blink window, stop off.
// - Up to 3 armed breakpoints; reaching one in run enters hold.
// - Single stepping refused with more than 2 breakpoints defined.
// - Hold blinks run, lights stop, halts all execution levels.
// - Hold freezes timers, clock runs, outputs inhibited, links kept.
// - 100 ms watchdog expiry resets into defined stop.
// - Cycle time limit, at least 1 ms, violation forces stop.
// - Run to stop inhibits central digital and analog outputs.
// - Disabled analog: 0 V, 0 mA, 4 mA, or substitute values.
// - Decentral outputs follow central ones; stations keep reading inputs.
// - Start: clear input image, handler, then cycles; inhibit released after first input read.
// - Run cycle: read input image, cyclic program, write output image.
// - Overall reset erases user memory, not memory card.
`timescale 1ns/1ps
module plc_operating_mode_sequencer
#(
   parameter int BLINK_MIN_CYC = mode_seq_pkg::BLINK_MIN_CYC,
   parameter int WDOG_CYC      = mode_seq_pkg::WDOG_CYC,
   parameter int BLINK_HALF    = mode_seq_pkg::BLINK_HALF_CYC,
   parameter int AO_CH         = 2
)
(
   // Clock and reset
   input  wire logic                ref_clk,
   input  wire logic                nrst,
   input  wire logic                clk_en,
   // Mode requests
   input  wire logic                run_req,
   input  wire logic                stop_req,
   input  wire logic                overall_reset_req,
   // Program engine handshakes
   input  wire logic                startup_done,
   input  wire logic                in_clr_done,
   input  wire logic                in_read_done,
   input  wire logic                program_done,
   input  wire logic                out_write_done,
   input  wire logic                watchdog_kick,
   input  wire logic [31:0]         cycle_limit_cyc,
   // Debug
   input  wire logic [1:0]          bp_defined,
   input  wire logic                bp_armed,
   input  wire logic                bp_reached,
   input  wire logic                step_req,
   input  wire logic                resume_req,
   // Analog output configuration
   input  wire logic [2*AO_CH-1:0]  ao_range,
   input  wire logic [AO_CH-1:0]    ao_subst_en,
   input  wire logic [16*AO_CH-1:0] ao_subst_val,
   input  wire logic [16*AO_CH-1:0] ao_prog_val,
   // Mode and indicators
   output logic [3:0]               mode,
   output logic                     output_inhibit,
   output logic                     run_led,
   output logic                     stop_led,
   // Sequencing strobes
   output logic                     startup_handler_block,
   output logic                     cyclic_program_block,
   output logic                     input_image_clear,
   output logic                     input_image_read,
   output logic                     output_image_clear,
   output logic                     output_image_write,
   output logic                     timers_run,
   output logic                     step_grant,
   output logic                     step_refused,
   output logic                     user_mem_erase,
   output logic                     fault_stop,
   // Analog outputs
   output logic [16*AO_CH-1:0]      ao_out
);
   mode_seq_pkg::mode_t  mode_reg;
   mode_seq_pkg::mode_t  mode_next;
   mode_seq_pkg::phase_t ph_reg;
   logic [31:0]          blink_cnt_reg;
   logic [31:0]          hold_cnt_reg;
   logic                 blink_reg;
   logic [31:0]          wdog_cnt_reg;
   logic [31:0]          cyc_cnt_reg;
   logic                 wdog_trip;
   logic                 cyc_trip;
   logic [31:0]          cyc_limit;
   logic                 first_cyc_reg;
   logic                 out_release;

   // ---------------------------------------------------------------
   // Supervision
   // ---------------------------------------------------------------
   assign cyc_limit = (cycle_limit_cyc < 32'(mode_seq_pkg::CYC_MIN_CYC))
                    ? 32'(mode_seq_pkg::CYC_MIN_CYC) : cycle_limit_cyc;
   assign wdog_trip = (mode_reg == mode_seq_pkg::MODE_RUN) &&
                      (wdog_cnt_reg >= 32'(WDOG_CYC - 1)) &&
                      !watchdog_kick;
   assign cyc_trip  = (mode_reg == mode_seq_pkg::MODE_RUN) &&
                      (cyc_cnt_reg >= cyc_limit - 32'h0000_0001);

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         wdog_cnt_reg <= 32'h0000_0000;
      else if (clk_en)
      begin
         if (mode_reg != mode_seq_pkg::MODE_RUN || watchdog_kick)
            wdog_cnt_reg <= 32'h0000_0000;
         else
            wdog_cnt_reg <= wdog_cnt_reg + 32'h0000_0001;
      end
   end

   // Cycle timer counts only run cycles; start-up and hold exempt
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         cyc_cnt_reg <= 32'h0000_0000;
      else if (clk_en)
      begin
         if (mode_reg != mode_seq_pkg::MODE_RUN ||
             ph_reg == mode_seq_pkg::PH_WRITE_OUT)
            cyc_cnt_reg <= 32'h0000_0000;
         else
            cyc_cnt_reg <= cyc_cnt_reg + 32'h0000_0001;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         fault_stop <= 1'b0;
      else if (clk_en)
      begin
         if (wdog_trip || cyc_trip)
            fault_stop <= 1'b1;
         else if (run_req && mode_reg == mode_seq_pkg::MODE_STOP)
            fault_stop <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Mode machine
   // ---------------------------------------------------------------
   always_comb
   begin
      mode_next = mode_reg;
      case (mode_reg)
         mode_seq_pkg::MODE_STOP:
            if (run_req && !stop_req && !overall_reset_req)
               mode_next = mode_seq_pkg::MODE_STARTUP;
         mode_seq_pkg::MODE_STARTUP:
            if (stop_req)
               mode_next = mode_seq_pkg::MODE_STOP;
            else if (startup_done && ph_reg == mode_seq_pkg::PH_IDLE)
               mode_next = mode_seq_pkg::MODE_RUN;
         mode_seq_pkg::MODE_RUN:
            if (stop_req || wdog_trip || cyc_trip)
               mode_next = mode_seq_pkg::MODE_STOP;
            else if (bp_reached && bp_armed &&
                     bp_defined <= 2'(mode_seq_pkg::MAX_BREAKPOINTS))
               mode_next = mode_seq_pkg::MODE_HOLD;
         mode_seq_pkg::MODE_HOLD:
            if (stop_req)
               mode_next = mode_seq_pkg::MODE_STOP;
            else if (resume_req)
               mode_next = mode_seq_pkg::MODE_RUN;
         default:
            mode_next = mode_seq_pkg::MODE_STOP;
      endcase
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         mode_reg <= mode_seq_pkg::MODE_STOP;
      else if (clk_en)
         mode_reg <= mode_next;
   end

   // ---------------------------------------------------------------
   // Cycle phase sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ph_reg        <= mode_seq_pkg::PH_IDLE;
         first_cyc_reg <= 1'b0;
      end
      else if (clk_en)
      begin
         if (mode_reg == mode_seq_pkg::MODE_STOP &&
             mode_next == mode_seq_pkg::MODE_STARTUP)
            ph_reg <= mode_seq_pkg::PH_CLR_IN;
         else if (mode_reg == mode_seq_pkg::MODE_STARTUP &&
                  mode_next == mode_seq_pkg::MODE_RUN)
         begin
            ph_reg        <= mode_seq_pkg::PH_READ_IN;
            first_cyc_reg <= 1'b1;
         end
         else if (mode_reg == mode_seq_pkg::MODE_STOP)
            ph_reg <= mode_seq_pkg::PH_IDLE;
         else
            case (ph_reg)
               mode_seq_pkg::PH_CLR_IN:
                  if (in_clr_done)
                     ph_reg <= mode_seq_pkg::PH_IDLE;
               mode_seq_pkg::PH_READ_IN:
                  if (in_read_done)
                  begin
                     ph_reg        <= mode_seq_pkg::PH_PROGRAM;
                     first_cyc_reg <= 1'b0;
                  end
               mode_seq_pkg::PH_PROGRAM:
                  if (program_done && mode_reg == mode_seq_pkg::MODE_RUN)
                     ph_reg <= mode_seq_pkg::PH_WRITE_OUT;
               mode_seq_pkg::PH_WRITE_OUT:
                  if (out_write_done)
                     ph_reg <= mode_seq_pkg::PH_READ_IN;
               mode_seq_pkg::PH_IDLE:
                  ph_reg <= mode_seq_pkg::PH_IDLE;
               default:
                  ph_reg <= mode_seq_pkg::PH_IDLE;
            endcase
      end
   end

   // ---------------------------------------------------------------
   // Indicators
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         blink_cnt_reg <= 32'h0000_0000;
         blink_reg     <= 1'b0;
      end
      else if (clk_en)
      begin
         if (blink_cnt_reg >= 32'(BLINK_HALF - 1))
         begin
            blink_cnt_reg <= 32'h0000_0000;
            blink_reg     <= !blink_reg;
         end
         else
            blink_cnt_reg <= blink_cnt_reg + 32'h0000_0001;
      end
   end

   // Minimum start-up blink window
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         hold_cnt_reg <= 32'h0000_0000;
      else if (clk_en)
      begin
         if (mode_reg == mode_seq_pkg::MODE_STOP &&
             mode_next == mode_seq_pkg::MODE_STARTUP)
            hold_cnt_reg <= 32'(BLINK_MIN_CYC);
         else if (hold_cnt_reg != 32'h0000_0000)
            hold_cnt_reg <= hold_cnt_reg - 32'h0000_0001;
      end
   end

   // Outputs stay inhibited through run entry and the first cycle's input read
   assign out_release = (mode_next == mode_seq_pkg::MODE_RUN) &&
                        (mode_reg != mode_seq_pkg::MODE_STARTUP) &&
                        !first_cyc_reg;

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         run_led        <= 1'b0;
         stop_led       <= 1'b1;
         output_inhibit <= 1'b1;
         timers_run     <= 1'b0;
         mode           <= 4'h1;
      end
      else if (clk_en)
      begin
         mode           <= mode_next;
         output_inhibit <= !out_release;
         timers_run     <= (mode_next == mode_seq_pkg::MODE_RUN);
         stop_led       <= (mode_next == mode_seq_pkg::MODE_STOP) ||
                           (mode_next == mode_seq_pkg::MODE_HOLD);
         if (hold_cnt_reg != 32'h0000_0000 ||
             mode_next == mode_seq_pkg::MODE_STARTUP ||
             mode_next == mode_seq_pkg::MODE_HOLD)
            run_led <= blink_reg;
         else
            run_led <= (mode_next == mode_seq_pkg::MODE_RUN);
      end
   end

   // ---------------------------------------------------------------
   // Strobes
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         startup_handler_block <= 1'b0;
         cyclic_program_block  <= 1'b0;
         input_image_clear     <= 1'b0;
         input_image_read      <= 1'b0;
         output_image_clear    <= 1'b0;
         output_image_write    <= 1'b0;
         step_grant            <= 1'b0;
         step_refused          <= 1'b0;
         user_mem_erase        <= 1'b0;
      end
      else if (clk_en)
      begin
         input_image_clear     <= (ph_reg == mode_seq_pkg::PH_CLR_IN);
         startup_handler_block <= mode_reg == mode_seq_pkg::MODE_STARTUP &&
                                  ph_reg == mode_seq_pkg::PH_IDLE;
         output_image_clear    <= first_cyc_reg &&
                                  ph_reg == mode_seq_pkg::PH_READ_IN;
         input_image_read      <= (ph_reg == mode_seq_pkg::PH_READ_IN) &&
                                  mode_reg == mode_seq_pkg::MODE_RUN;
         cyclic_program_block  <= (ph_reg == mode_seq_pkg::PH_PROGRAM) &&
                                  mode_reg == mode_seq_pkg::MODE_RUN;
         output_image_write    <= ph_reg == mode_seq_pkg::PH_WRITE_OUT;
         step_grant            <= step_req &&
                                  mode_reg == mode_seq_pkg::MODE_HOLD &&
                                  bp_defined <= 2'(mode_seq_pkg::STEP_MAX_BP);
         step_refused          <= step_req &&
                                  bp_defined > 2'(mode_seq_pkg::STEP_MAX_BP);
         user_mem_erase        <= overall_reset_req &&
                                  mode_reg == mode_seq_pkg::MODE_STOP;
      end
   end

   // ---------------------------------------------------------------
   // Analog safe states
   // ---------------------------------------------------------------
   for (genvar i = 0; i < AO_CH; i++)
   begin : g_ao
      always_ff @(posedge ref_clk or negedge nrst)
      begin
         if (!nrst)
            ao_out[16*i +: 16] <= mode_seq_pkg::AO_ZERO;
         else if (clk_en)
         begin
            if (out_release)
               ao_out[16*i +: 16] <= ao_prog_val[16*i +: 16];
            else if (ao_subst_en[i])
               ao_out[16*i +: 16] <= ao_subst_val[16*i +: 16];
            else if (ao_range[2*i +: 2] == mode_seq_pkg::RANGE_CUR_4)
               ao_out[16*i +: 16] <= mode_seq_pkg::AO_FOUR_MA;
            else
               ao_out[16*i +: 16] <= mode_seq_pkg::AO_ZERO;
         end
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   property p_stop_outputs;
      @(posedge ref_clk) disable iff (!nrst)
      (mode == 4'h1) |-> (output_inhibit && stop_led);
   endproperty
   a_stop_outputs: assert property (p_stop_outputs)
      else $error("stop mode outputs wrong");

   property p_run_trip;
      @(posedge ref_clk) disable iff (!nrst)
      (clk_en && (wdog_trip || cyc_trip)) |=>
      (mode_reg == mode_seq_pkg::MODE_STOP);
   endproperty
   a_run_trip: assert property (p_run_trip)
      else $error("supervision trip did not stop");

   property p_step_refuse;
      @(posedge ref_clk) disable iff (!nrst)
      (clk_en && step_req && bp_defined == 2'h3) |=>
      (step_refused && !step_grant);
   endproperty
   a_step_refuse: assert property (p_step_refuse)
      else $error("single step not refused");

   property p_startup_outputs;
      @(posedge ref_clk) disable iff (!nrst)
      (mode == 4'h2) |-> (output_inhibit && !stop_led);
   endproperty
   a_startup_outputs: assert property (p_startup_outputs)
      else $error("start-up outputs wrong");

   property p_run_outputs;
      @(posedge ref_clk) disable iff (!nrst)
      (mode == 4'h4) |-> (!stop_led && timers_run);
   endproperty
   a_run_outputs: assert property (p_run_outputs)
      else $error("run mode outputs wrong");

   property p_hold_outputs;
      @(posedge ref_clk) disable iff (!nrst)
      (mode == 4'h8) |-> (stop_led && output_inhibit && !timers_run);
   endproperty
   a_hold_outputs: assert property (p_hold_outputs)
      else $error("hold mode outputs wrong");

   // Run left for stop
   sequence s_run_to_stop;
      (mode == 4'h4) ##1 (mode == 4'h1);
   endsequence

   property p_run_stop_inhibit;
      @(posedge ref_clk) disable iff (!nrst)
      s_run_to_stop |-> output_inhibit;
   endproperty
   a_run_stop_inhibit: assert property (p_run_stop_inhibit)
      else $error("run to stop left outputs enabled");
endmodule

// *** verification/engine_model.sv ***
`timescale 1ns/1ps
module engine_model
(
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   // Pacing
   input  wire logic [7:0] delay,
   input  wire logic       stall,
   // Phase strobes from the sequencer
   input  wire logic [4:0] req,
   // Completions
   output logic      [4:0] done
);
   // ----------------------------------------
   // One responder per phase strobe
   // ----------------------------------------
   for (genvar i = 0; i < 5; i++)
   begin : g_resp
      logic [7:0] cnt_reg;
      logic       fired_reg;
      always_ff @(negedge ref_clk or negedge nrst)
      begin
         if (!nrst)
         begin
            cnt_reg   <= 8'h00;
            fired_reg <= 1'b0;
            done[i]   <= 1'b0;
         end
         else
         begin
            done[i] <= 1'b0;
            if (!req[i])
            begin
               cnt_reg   <= 8'h00;
               fired_reg <= 1'b0;
            end
            else if (!fired_reg && !stall)
            begin
               if (cnt_reg >= delay)
               begin
                  done[i]   <= 1'b1;
                  fired_reg <= 1'b1;
               end
               else
                  cnt_reg <= cnt_reg + 8'h01;
            end
         end
      end
   end
endmodule

// *** verification/plc_operating_mode_sequencer_bench.sv ***
`timescale 1ns/1ps
module plc_operating_mode_sequencer_bench;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic        ref_clk, nrst, clk_en, run_req, stop_req;
   logic        overall_reset_req, startup_done, in_clr_done;
   logic        in_read_done, program_done, out_write_done;
   logic        watchdog_kick, bp_armed, bp_reached, step_req;
   logic        resume_req, output_inhibit, run_led, stop_led;
   logic        startup_handler_block, cyclic_program_block;
   logic        input_image_clear, input_image_read;
   logic        output_image_clear, output_image_write, timers_run;
   logic        step_grant, step_refused, user_mem_erase, fault_stop;
   logic        stall, kick_on;
   logic [1:0]  bp_defined;
   logic [3:0]  mode, ao_subst_en;
   logic [7:0]  ao_range;
   logic [31:0] cycle_limit_cyc;
   logic [63:0] ao_subst_val, ao_prog_val, ao_out;
   int          n_mismatch, comparisons, kcnt, t;

   plc_operating_mode_sequencer
   #(
      .BLINK_MIN_CYC (100),
      .WDOG_CYC      (50),
      .BLINK_HALF    (4),
      .AO_CH         (4)
   )
   uut
   (
      .ref_clk, .nrst, .clk_en, .run_req, .stop_req, .overall_reset_req,
      .startup_done, .in_clr_done, .in_read_done, .program_done,
      .out_write_done, .watchdog_kick, .cycle_limit_cyc, .bp_defined,
      .bp_armed, .bp_reached, .step_req, .resume_req, .ao_range,
      .ao_subst_en, .ao_subst_val, .ao_prog_val, .mode, .output_inhibit,
      .run_led, .stop_led, .startup_handler_block, .cyclic_program_block,
      .input_image_clear, .input_image_read, .output_image_clear,
      .output_image_write, .timers_run, .step_grant, .step_refused,
      .user_mem_erase, .fault_stop, .ao_out
   );

   engine_model engine
   (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .delay   (8'h02),
      .stall   (stall),
      .req     ({output_image_write, cyclic_program_block,
                 input_image_read, startup_handler_block,
                 input_image_clear}),
      .done    ({out_write_done, program_done, in_read_done,
                 startup_done, in_clr_done})
   );

   // ----------------------------------------
   // Clock and watchdog service
   // ----------------------------------------
   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   always @(negedge ref_clk)
   begin
      kcnt <= kcnt + 1;
      watchdog_kick <= kick_on && (kcnt % 20 == 0);
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic check(input string what, input logic [63:0] seen, exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   function automatic logic probe(input int k);
      case (k)
         0: return input_image_clear;
         1: return startup_handler_block;
         2: return input_image_read;
         3: return cyclic_program_block;
         4: return output_image_write;
         5: return step_grant;
         6: return step_refused;
         7: return user_mem_erase;
         8: return fault_stop;
         9: return mode === mode_seq_pkg::MODE_STOP;
         10: return mode === mode_seq_pkg::MODE_STARTUP;
         11: return mode === mode_seq_pkg::MODE_RUN;
         default: return mode === mode_seq_pkg::MODE_HOLD;
      endcase
   endfunction

   task automatic wait_on(input int k, input int lim);
      int i;
      i = 0;
      while (probe(k) !== 1'b1 && i < lim)
      begin
         @(negedge ref_clk);
         i++;
      end
      if (probe(k) !== 1'b1)
      begin
         n_mismatch++;
         $display("mismatch wait %0d expected 1 seen 0", k);
         tally_and_finish();
      end
   endtask

   // Mask bits: run, stop, overall reset, breakpoint, step, resume
   task automatic pulse_in(input logic [5:0] m);
      @(negedge ref_clk);
      {resume_req, step_req, bp_reached, overall_reset_req, stop_req,
       run_req} = m;
      @(negedge ref_clk);
      {resume_req, step_req, bp_reached, overall_reset_req, stop_req,
       run_req} = 6'h00;
   endtask

   task automatic toggles(input int n, output int c);
      logic prev;
      c = 0;
      prev = run_led;
      repeat (n)
      begin
         @(negedge ref_clk);
         if (run_led !== prev)
            c++;
         prev = run_led;
      end
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      check("mode", mode, mode_seq_pkg::MODE_STOP);
      check("inhibit", output_inhibit, 1);
      check("stop_led", stop_led, 1);
      check("run_led", run_led, 0);
      check("program", cyclic_program_block, 0);
   endtask

   task automatic t_start;
      stall = 1'b1;
      pulse_in(6'h01);
      wait_on(10, 4);
      check("inhibit", output_inhibit, 1);
      check("stop_led", stop_led, 0);
      @(negedge ref_clk);
      check("in_clear", input_image_clear, 1);
      check("handler", startup_handler_block, 0);
      stall = 1'b0;
      wait_on(1, 20);
      stall = 1'b1;
      repeat (60) @(negedge ref_clk);
      check("mode", mode, mode_seq_pkg::MODE_STARTUP);
      check("fault", fault_stop, 0);
      stall = 1'b0;
      wait_on(11, 20);
      check("inhibit", output_inhibit, 1);
      @(negedge ref_clk);
      check("out_clear", output_image_clear, 1);
      toggles(16, t);
      check("blink", t > 0, 1);
   endtask

   task automatic t_cycle;
      ao_prog_val = 64'h4444_3333_2222_1111;
      wait_on(2, 40);
      check("program", cyclic_program_block, 0);
      wait_on(3, 20);
      check("read", input_image_read, 0);
      check("timers", timers_run, 1);
      wait_on(4, 20);
      check("program", cyclic_program_block, 0);
      repeat (120) @(negedge ref_clk);
      check("inhibit", output_inhibit, 1'b0);
      check("stop_led", stop_led, 0);
      toggles(12, t);
      check("steady", t, 0);
      check("run_led", run_led, 1);
      check("ao", ao_out, ao_prog_val);
   endtask

   task automatic t_hold;
      bp_defined = 2'd1;
      bp_armed = 1'b1;
      pulse_in(6'h08);
      wait_on(12, 4);
      check("stop_led", stop_led, 1);
      check("inhibit", output_inhibit, 1);
      check("timers", timers_run, 0);
      toggles(12, t);
      check("blink", t > 0, 1);
      for (int n = 2; n <= 3; n++)
      begin
         bp_defined = n[1:0];
         pulse_in(6'h10);
         check("grant", step_grant, n == 2);
         check("refused", step_refused, n == 3);
      end
      pulse_in(6'h20);
      wait_on(11, 4);
   endtask

   task automatic t_stop;
      pulse_in(6'h02);
      wait_on(9, 4);
      check("inhibit", output_inhibit, 1);
      check("run_led", run_led, 0);
      check("stop_led", stop_led, 1);
      check("ao", ao_out, {16'h0123, mode_seq_pkg::AO_FOUR_MA,
            mode_seq_pkg::AO_ZERO, mode_seq_pkg::AO_ZERO});
      repeat (5) @(negedge ref_clk);
      check("program", cyclic_program_block, 0);
      pulse_in(6'h03);
      repeat (5) @(negedge ref_clk);
      check("mode", mode, mode_seq_pkg::MODE_STOP);
      pulse_in(6'h04);
      wait_on(7, 3);
      check("erase", user_mem_erase, 1);
   endtask

   task automatic t_faults;
      pulse_in(6'h01);
      wait_on(11, 200);
      kick_on = 1'b0;
      stall = 1'b1;
      wait_on(8, 80);
      check("mode", mode, mode_seq_pkg::MODE_STOP);
      kick_on = 1'b1;
      stall = 1'b0;
      pulse_in(6'h01);
      wait_on(11, 200);
      stall = 1'b1;
      repeat (30000) @(negedge ref_clk);
      check("early", fault_stop, 0);
      wait_on(8, 11000);
      check("mode", mode, mode_seq_pkg::MODE_STOP);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      n_mismatch = 0;
      comparisons = 0;
      kick_on = 1'b1;
      stall = 1'b0;
      nrst = 1'b0;
      clk_en = 1'b1;
      {resume_req, step_req, bp_reached, overall_reset_req, stop_req,
       run_req} = 6'h00;
      bp_defined = 2'd0;
      bp_armed = 1'b0;
      cycle_limit_cyc = 32'h0000_0064;
      ao_range = 8'ha4;
      ao_subst_en = 4'h8;
      ao_subst_val = 64'h0123_0000_0000_0000;
      ao_prog_val = 64'h0000_0000_0000_0000;
      repeat (2) @(negedge ref_clk);
      t_reset();
      nrst = 1'b1;
      t_start();
      t_cycle();
      t_hold();
      t_stop();
      t_faults();
      tally_and_finish();
   end
endmodule
